/* ledcfg_map.svh */
`ifndef LEDCFG_MAP_SVH
`define LEDCFG_MAP_SVH
// Register addresses (8-bit register pointer on the serial port)
`define LEDCFG_ADDR_FS_EN     8'h00
`define LEDCFG_ADDR_PARAMS    8'h01
`define LEDCFG_ADDR_FUSE_AMP  8'h02
`define LEDCFG_ADDR_SLOPE     8'h03
`define LEDCFG_ADDR_DUTY      8'h04
// Parameter register fields
`define LEDCFG_OVP_LSB        8
`define LEDCFG_SYNC_BIT       7
`define LEDCFG_MOD_LSB        4
`define LEDCFG_INDUCTOR_CURRENT_LIMIT_SEL_BIT       3
`define LEDCFG_FS_LSB         0
`define LEDCFG_PARAMS_MASK    16'h03ff
`define LEDCFG_PARAMS_RST     16'h01cb
// Fuse and amplitude register fields
`define LEDCFG_FMODE_BIT      11
`define LEDCFG_FBURN_BIT      10
`define LEDCFG_AMP_MASK       16'h03ff
`define LEDCFG_FUSE_AMP_RST   16'h03ff
// Other held registers
`define LEDCFG_FS_EN_RST      16'hffff
`define LEDCFG_SLOPE_MASK     16'h07ff
`define LEDCFG_SLOPE_RST      16'h027e
`define LEDCFG_DIMT_LSB       0
`define LEDCFG_DUTY_MASK      16'h3fff
`define LEDCFG_DUTY_RST       16'h0000
// Fuse burn: five registers then the event count
`define LEDCFG_BURN_WORDS     3'h6
`define LEDCFG_BURN_TIME_NS   1000
`define LEDCFG_BURN_CYC       ((`LEDCFG_BURN_TIME_NS + 24) / 25)
`endif

/* ledcfg_pkg.sv */
package ledcfg_pkg;
  typedef enum logic [2:0] {
    LEDCFG_DIM_ANA_PIN = 3'h0,
    LEDCFG_DIM_ANA_SER = 3'h1,
    LEDCFG_DIM_MIX_PIN = 3'h4,
    LEDCFG_DIM_MIX_SER = 3'h5
  } ledcfg_dim_t;
  typedef enum logic [1:0] {
    LEDCFG_FRS_IDLE,
    LEDCFG_FRS_WORD,
    LEDCFG_FRS_DONE
  } ledcfg_fstate_t;
endpackage

/* ledcfg_dim.sv */
`timescale 1ns/1ps
`include "ledcfg_map.svh"
module ledcfg_dim #(
  parameter int DW = 14
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Settings
  input  wire logic [2:0]    dimming_scheme_sel,
  input  wire logic [1:0]    mix_transfer_point,
  input  wire logic [9:0]    amplitude_level,
  input  wire logic [DW-1:0] duty_setting_word,
  // Synchronised external dimming pin
  input  wire logic          pwm_in_sync,
  // Results
  output logic [9:0]         amp_out,
  output logic               pwm_gate,
  output logic               scheme_valid
);
  logic [DW-1:0] win_cnt;
  logic [DW-1:0] hi_cnt;
  logic [DW-1:0] pin_duty;
  logic [DW-1:0] duty;
  logic [DW-1:0] thresh;
  logic          analog;

  // Pin duty measured over a fixed window of 2^DW clocks
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      win_cnt  <= '0;
      hi_cnt   <= '0;
      pin_duty <= '0;
    end
    else
    begin
      win_cnt <= win_cnt + 1'b1;
      if (&win_cnt)
      begin
        // Saturate: a pin high for the whole window would wrap to zero
        pin_duty <= (&hi_cnt) ? hi_cnt : hi_cnt + DW'(pwm_in_sync);
        hi_cnt   <= '0;
      end
      else
        hi_cnt <= hi_cnt + DW'(pwm_in_sync);
    end

  always_comb
  begin
    duty   = dimming_scheme_sel[0] ? duty_setting_word : pin_duty;
    thresh = DW'(1) << (DW - 4 + 32'(mix_transfer_point));
    analog = !dimming_scheme_sel[2] || (duty > thresh);
  end

  // Current scale: amplitude times duty in analog, amplitude alone when chopping
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      amp_out      <= '0;
      pwm_gate     <= 1'b0;
      scheme_valid <= 1'b0;
    end
    else
    begin
      scheme_valid <= (dimming_scheme_sel[1] == 1'b0);
      if (analog)
      begin
        amp_out  <= 10'(({10'h0, amplitude_level} * {10'h0, duty}) >> DW);
        pwm_gate <= 1'b1;
      end
      else
      begin
        amp_out  <= amplitude_level;
        pwm_gate <= (win_cnt < duty);
      end
    end
endmodule

/* ledcfg_regs.sv */
`timescale 1ns/1ps
`include "ledcfg_map.svh"
module ledcfg_regs #(
  parameter int BURN_CYC = `LEDCFG_BURN_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port from the serial slave
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // External dimming pin
  input  wire logic        pwm_in,
  // Thermal event count to store
  input  wire logic [1:0]  thermal_event_count,
  // Converter controls
  output logic [1:0]       overvoltage_threshold_sel,
  output logic             sync_rectifier,
  output logic             inductor_current_limit_sel,
  output logic [2:0]       switch_freq_sel,
  output logic             ovp_code_invalid,
  // Dimming results
  output logic [9:0]       led_amplitude,
  output logic             led_pwm_gate,
  output logic             dim_scheme_valid,
  // Fuse array write port
  output logic             fuse_wr,
  output logic [2:0]       fuse_index,
  output logic [15:0]      fuse_data
);
  logic [15:0] fs_en;
  logic [15:0] params;
  logic [1:0]  fuse_ctl;
  logic [9:0]  amplitude_level;
  logic [15:0] slope;
  logic [13:0] duty_setting_word;
  logic [2:0]  burn_idx;
  logic [15:0] burn_cnt;
  logic [1:0]  pwm_meta;
  logic [1:0]  pwm_sync;
  logic [9:0]  amp_d;
  logic        gate_d;
  logic        valid_d;
  logic [15:0] next_rdata;
  ledcfg_pkg::ledcfg_fstate_t fstate;

  function automatic logic [15:0] reg_value(input logic [2:0] idx);
    unique case (idx)
      3'h0:    reg_value = fs_en;
      3'h1:    reg_value = params & `LEDCFG_PARAMS_MASK;
      3'h2:    reg_value = {4'h0, fuse_ctl, amplitude_level};
      3'h3:    reg_value = slope & `LEDCFG_SLOPE_MASK;
      3'h4:    reg_value = {2'h0, duty_setting_word};
      3'h5:    reg_value = {14'h0, thermal_event_count};
      default: reg_value = 16'h0000;
    endcase
  endfunction

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      pwm_meta <= 2'h0;
      pwm_sync <= 2'h0;
    end
    else
    begin
      pwm_meta <= {pwm_meta[0], pwm_in};
      pwm_sync <= {pwm_sync[0], pwm_meta[1]};
    end

  // Host writes; reserved bits are masked away on the way in
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      fs_en             <= `LEDCFG_FS_EN_RST;
      params            <= `LEDCFG_PARAMS_RST;
      amplitude_level   <= 10'(`LEDCFG_FUSE_AMP_RST & `LEDCFG_AMP_MASK);
      slope             <= `LEDCFG_SLOPE_RST;
      duty_setting_word <= 14'(`LEDCFG_DUTY_RST);
    end
    else if (reg_wr)
      unique case (reg_addr)
        `LEDCFG_ADDR_FS_EN:    fs_en <= reg_wdata;
        `LEDCFG_ADDR_PARAMS:   params <= reg_wdata & `LEDCFG_PARAMS_MASK;
        `LEDCFG_ADDR_FUSE_AMP: amplitude_level <= reg_wdata[9:0];
        `LEDCFG_ADDR_SLOPE:    slope <= reg_wdata & `LEDCFG_SLOPE_MASK;
        `LEDCFG_ADDR_DUTY:     duty_setting_word <= reg_wdata[13:0];
        default:               ;
      endcase

  // Fuse control bits; a host write in the completion cycle wins, so none is lost
  always_ff @(posedge clk or posedge rst)
    if (rst)
      fuse_ctl <= 2'h0;
    else if (reg_wr && reg_addr == `LEDCFG_ADDR_FUSE_AMP)
      fuse_ctl <= {reg_wdata[`LEDCFG_FMODE_BIT], reg_wdata[`LEDCFG_FBURN_BIT]};
    else if (fstate == ledcfg_pkg::LEDCFG_FRS_DONE)
      fuse_ctl[0] <= 1'b0;

  // Burn sequencer: one word per slot, each strobe held for the burn time
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      fstate   <= ledcfg_pkg::LEDCFG_FRS_IDLE;
      burn_idx <= 3'h0;
      burn_cnt <= 16'h0000;
    end
    else
      unique case (fstate)
        ledcfg_pkg::LEDCFG_FRS_IDLE:
          if (fuse_ctl[1] && fuse_ctl[0])
          begin
            fstate   <= ledcfg_pkg::LEDCFG_FRS_WORD;
            burn_idx <= 3'h0;
            burn_cnt <= 16'(BURN_CYC - 1);
          end
        ledcfg_pkg::LEDCFG_FRS_WORD:
          if (!fuse_ctl[1])
            fstate <= ledcfg_pkg::LEDCFG_FRS_DONE;
          else if (burn_cnt != 16'h0000)
            burn_cnt <= burn_cnt - 16'h0001;
          else if (burn_idx == `LEDCFG_BURN_WORDS - 3'h1)
            fstate <= ledcfg_pkg::LEDCFG_FRS_DONE;
          else
          begin
            burn_idx <= burn_idx + 3'h1;
            burn_cnt <= 16'(BURN_CYC - 1);
          end
        ledcfg_pkg::LEDCFG_FRS_DONE:
          fstate <= ledcfg_pkg::LEDCFG_FRS_IDLE;
        default:
          fstate <= ledcfg_pkg::LEDCFG_FRS_IDLE;
      endcase

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      fuse_wr    <= 1'b0;
      fuse_index <= 3'h0;
      fuse_data  <= 16'h0000;
    end
    else
    begin
      fuse_wr    <= (fstate == ledcfg_pkg::LEDCFG_FRS_WORD) && fuse_ctl[1];
      fuse_index <= burn_idx;
      fuse_data  <= reg_value(burn_idx);
    end

  always_comb
    next_rdata = reg_value(reg_addr[7:3] == 5'h00 ? reg_addr[2:0] : 3'h7);

  always_ff @(posedge clk or posedge rst)
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= next_rdata;

  // Converter outputs registered from fields, plus ovp_code_invalid set when the OVP code is all ones
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      overvoltage_threshold_sel  <= 2'h1;
      sync_rectifier             <= 1'b1;
      inductor_current_limit_sel <= 1'b1;
      switch_freq_sel            <= 3'h3;
      ovp_code_invalid           <= 1'b0;
    end
    else
    begin
      overvoltage_threshold_sel  <= params[`LEDCFG_OVP_LSB +: 2];
      ovp_code_invalid           <= &params[`LEDCFG_OVP_LSB +: 2];
      sync_rectifier             <= params[`LEDCFG_SYNC_BIT];
      inductor_current_limit_sel <= params[`LEDCFG_INDUCTOR_CURRENT_LIMIT_SEL_BIT];
      switch_freq_sel            <= params[`LEDCFG_FS_LSB +: 3];
    end

  ledcfg_dim #(
    .DW (14)
  ) u_dim (
    .clk                (clk),
    .rst                (rst),
    .dimming_scheme_sel (params[`LEDCFG_MOD_LSB +: 3]),
    .mix_transfer_point (slope[`LEDCFG_DIMT_LSB +: 2]),
    .amplitude_level    (amplitude_level),
    .duty_setting_word  (duty_setting_word),
    .pwm_in_sync        (pwm_sync[1]),
    .amp_out            (amp_d),
    .pwm_gate           (gate_d),
    .scheme_valid       (valid_d)
  );

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      led_amplitude    <= 10'h000;
      led_pwm_gate     <= 1'b0;
      dim_scheme_valid <= 1'b0;
    end
    else
    begin
      led_amplitude    <= amp_d;
      led_pwm_gate     <= gate_d;
      dim_scheme_valid <= valid_d;
    end
endmodule

/* ledcfg_regs_asserts.sv */
`timescale 1ns/1ps
module ledcfg_regs_asserts #(
  parameter int BURN_CYC = 40
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register port and inputs
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [1:0]  thermal_event_count,
  // Controls
  input wire logic [1:0]  overvoltage_threshold_sel,
  input wire logic        sync_rectifier,
  input wire logic        inductor_current_limit_sel,
  input wire logic [2:0]  switch_freq_sel,
  input wire logic        ovp_code_invalid,
  // Fuse port
  input wire logic        fuse_wr,
  input wire logic [2:0]  fuse_index,
  input wire logic [15:0] fuse_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic wp;
  logic wf;
  assign wp = reg_wr && reg_addr == 8'h01;
  assign wf = reg_wr && reg_addr == 8'h02;
  chk_ovp_follow:
    assert property (wp |-> ##2 overvoltage_threshold_sel == $past(reg_wdata[9:8], 2))
    else $error("ovp select lost");
  chk_ovp_flag:
    assert property (ovp_code_invalid == (overvoltage_threshold_sel == 2'h3))
    else $error("ovp flag wrong");
  chk_sync_follow:
    assert property (wp |-> ##2 sync_rectifier == $past(reg_wdata[7], 2))
    else $error("sync bit lost");
  chk_inductor_current_limit_sel_follow:
    assert property (wp |-> ##2 inductor_current_limit_sel == $past(reg_wdata[3], 2))
    else $error("limit bit lost");
  chk_freq_follow:
    assert property (wp |-> ##2 switch_freq_sel == $past(reg_wdata[2:0], 2))
    else $error("frequency lost");
  chk_unmapped_zero:
    assert property (reg_rd && reg_addr > 8'h05 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_reserved_zero:
    assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata[15:12] == 4'h0)
    else $error("reserved bits set");
  chk_burn_start:
    assert property (wf && reg_wdata[11:10] == 2'h3 && !fuse_wr
      |-> ##3 fuse_wr && fuse_index == 3'h0)
    else $error("burn did not start");
  chk_burn_refused:
    assert property (wf && !reg_wdata[11] |-> ##2 !fuse_wr)
    else $error("burn outside fuse mode");
  chk_index_order:
    assert property (fuse_wr && $past(fuse_wr) && $changed(fuse_index)
      |-> fuse_index == $past(fuse_index) + 3'h1)
    else $error("burn order wrong");
  chk_count_last:
    assert property (fuse_wr && fuse_index == 3'h5 |-> fuse_data == {14'h0000, thermal_event_count})
    else $error("event count word wrong");
  chk_index_start:
    assert property ($rose(fuse_wr) |-> fuse_index == 3'h0)
    else $error("burn did not begin at word zero");
endmodule
bind ledcfg_regs ledcfg_regs_asserts #(.BURN_CYC(BURN_CYC)) chk_i (.clk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .thermal_event_count, .overvoltage_threshold_sel,
  .sync_rectifier, .inductor_current_limit_sel, .switch_freq_sel, .ovp_code_invalid, .fuse_wr,
  .fuse_index, .fuse_data);

/* ledcfg_host.sv */
`timescale 1ns/1ps
module ledcfg_host (
  // Clock
  input  wire logic        clk,
  // Register port
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle lines show the inverse, so a stale copy is never mistaken for data
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        clk, rst, reg_wr, reg_rd, pwm_in, sync_rectifier, inductor_current_limit_sel;
  logic        ovp_code_invalid, dim_scheme_valid, fuse_wr, led_pwm_gate;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, fuse_data, d, cfg_bits;
  logic [1:0]  thermal_event_count, overvoltage_threshold_sel;
  logic [2:0]  switch_freq_sel, fuse_index, last;
  logic [9:0]  led_amplitude;
  int          fails, n_tests, cyc, k;
  ledcfg_regs #(.BURN_CYC(2)) ledcfg_regs_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .pwm_in, .thermal_event_count, .overvoltage_threshold_sel,
    .sync_rectifier, .inductor_current_limit_sel, .switch_freq_sel, .ovp_code_invalid,
    .led_amplitude, .led_pwm_gate, .dim_scheme_valid, .fuse_wr, .fuse_index, .fuse_data);
  ledcfg_host ledcfg_host_i (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  assign cfg_bits = {11'h0, sync_rectifier, inductor_current_limit_sel, switch_freq_sel};
  always #12.5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic amp_is(input logic [9:0] e);
    // Dimming latency is not fixed, so poll under a bound
    #1;
    for (int i = 0; i < 64 && led_amplitude !== e; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk({6'h00, led_amplitude}, {6'h00, e});
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    // Pin dimming waits out two 16384-cycle windows
    if (cyc == 40000)
    begin
      fails++;
      finish_test();
    end
  end
  initial
  begin
    {clk, rst, pwm_in, thermal_event_count} = 5'b01110;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    ledcfg_host_i.rd(8'h01, d);
    chk(d, 16'h01cb);
    chk(cfg_bits, 16'h001b);
    chk({14'h0, overvoltage_threshold_sel}, 16'h0001);
    ledcfg_host_i.rd(8'h02, d);
    chk(d, 16'h03ff);
    ledcfg_host_i.wr(8'h01, 16'hffff);
    settle();
    chk({15'h0, ovp_code_invalid}, 16'h0001);
    ledcfg_host_i.rd(8'h01, d);
    chk(d, 16'h03ff);
    ledcfg_host_i.wr(8'h01, 16'h02cb);
    settle();
    chk({14'h0, overvoltage_threshold_sel}, 16'h0002);
    chk({15'h0, ovp_code_invalid}, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      ledcfg_host_i.wr(8'h01, 16'(32'h0140 | (i[1] << 7) | (i[0] << 3) | i[2:0]));
      settle();
      chk(cfg_bits, 16'(i[1:0] * 8 + i[2:0]));
      ledcfg_host_i.wr(8'h01, 16'(32'h010b | (i << 4)));
      settle();
      chk({15'h0, dim_scheme_valid}, 16'((8'h33 >> i) & 1));
    end
    ledcfg_host_i.wr(8'h04, 16'h2000);
    ledcfg_host_i.wr(8'h02, 16'h0200);
    ledcfg_host_i.wr(8'h01, 16'h011b);
    amp_is(10'h100);
    ledcfg_host_i.wr(8'h03, 16'h027c);
    ledcfg_host_i.wr(8'h04, 16'h0400);
    ledcfg_host_i.wr(8'h02, 16'h0155);
    ledcfg_host_i.wr(8'h01, 16'h015b);
    amp_is(10'h155);
    ledcfg_host_i.wr(8'h04, 16'h0401);
    amp_is(10'h015);
    ledcfg_host_i.wr(8'h04, 16'h2000);
    ledcfg_host_i.wr(8'h03, 16'h027f);
    amp_is(10'h155);
    ledcfg_host_i.wr(8'h04, 16'h2001);
    amp_is(10'h0aa);
    chk({15'h0, led_pwm_gate}, 16'h0001);
    ledcfg_host_i.wr(8'h04, 16'h0000);
    amp_is(10'h155);
    chk({15'h0, led_pwm_gate}, 16'h0000);
    // Pin scheme: the second window sees the pin high in every cycle
    ledcfg_host_i.wr(8'h01, 16'h010b);
    repeat (33000) @(posedge clk);
    amp_is(10'h154);
    ledcfg_host_i.wr(8'h04, 16'hffff);
    ledcfg_host_i.rd(8'h04, d);
    chk(d, 16'h3fff);
    ledcfg_host_i.rd(8'h06, d);
    chk(d, 16'h0000);
    // Trigger without fuse mode must stay idle
    ledcfg_host_i.wr(8'h02, 16'h07ff);
    k = 0;
    repeat (10)
    begin
      @(posedge clk);
      #1;
      if (fuse_wr !== 1'b0)
        k++;
    end
    chk(16'(k), 16'h0000);
    ledcfg_host_i.wr(8'h02, 16'h0fff);
    k = 0;
    last = 3'h7;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      #1;
      if (fuse_wr === 1'b1 && fuse_index !== last)
      begin
        chk({13'h0, fuse_index}, 16'(k));
        if (k == 5)
          chk(fuse_data, 16'h0002);
        last = fuse_index;
        k++;
      end
    end
    chk(16'(k), 16'h0006);
    ledcfg_host_i.rd(8'h02, d);
    chk(d, 16'h0bff);
    ledcfg_host_i.wr(8'h02, 16'h0fff);
    repeat (4) @(posedge clk);
    ledcfg_host_i.wr(8'h02, 16'h03ff);
    settle();
    chk({15'h0, fuse_wr}, 16'h0000);
    ledcfg_host_i.rd(8'h02, d);
    chk(d, 16'h03ff);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    ledcfg_host_i.rd(8'h01, d);
    chk(d, 16'h01cb);
    chk(cfg_bits, 16'h001b);
    finish_test();
  end
endmodule
